// >>> jtda_tap.v
// Summary of operation
// - 4-bit instruction register shifts from tdi on tck rising edges in shift-ir.
// - tms 1,1,0 returns to idle; instruction latched in update-ir.
// - latched instruction picks the data register between tdi and tdo.
// - data shifted out on tdo is what capture-dr loaded.
// - latched data register outputs change only in update-dr.
// - tap reset makes identification the active instruction.
// - boundary chain drives and observes every pin level.
// - extest drives boundary latches onto pins once latched.
// - sample/preload snapshots pins and loads output latches without disturbing them.
// - device reset puts all boundary pin outputs at high impedance a few clocks after the pin drops.
// - boundary scan needs clk running: tck is sampled, never used as a clock.
// - bus port cannot write page buffer under core hold; none when protected.
// - tck low at reset release asserts core hold; rest of system runs.
// - writing one to release_core_bit frees the core and opens page buffer writes.
// - chip erase clears volatile memory, then flash, then protected state.
// - erase_complete_flag set when erase finishes; debugger polls it.
// - newly programmed protection takes effect only after chip reset.
// - five tck periods with tms high reach test-logic-reset from anywhere.
// - jtag pins enable on a tck falling edge after reset release.
// - tck high at reset release keeps the jtag pins disabled.
`include "jtda_consts.vh"

module jtda_tap #(
    parameter [31:0] ID_CODE = `JTDA_IDCODE_DEF  // arbitrary identification value
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   resetn,
    // jtag pins
    input  wire                   tckPin,
    input  wire                   tmsPin,
    input  wire                   tdiPin,
    output reg                    tdo,
    output reg                    tdoOe,
    // external reset pin
    input  wire                   extResetnPin,
    // boundary pins and core side
    input  wire [`JTDA_PINS-1:0]  padIn,
    output reg  [`JTDA_PINS-1:0]  padOut,
    output reg  [`JTDA_PINS-1:0]  padOe,
    input  wire [`JTDA_PINS-1:0]  coreOut,
    input  wire [`JTDA_PINS-1:0]  coreOe,
    // access port control and status
    input  wire                   releaseCoreWr,
    input  wire                   releaseCoreVal,
    input  wire                   eraseTriggerWr,
    input  wire                   protectProgrammed,
    output reg                    coreHoldReset,
    output wire                   coreHoldStatus,
    output reg                    coreRestartReq,
    output wire                   busAccessEnable,
    output wire                   pageBufWriteEnable,
    output reg                    protectedState,
    output reg                    eraseComplete,
    output wire                   jtagEnabled,
    // erase phase handshakes
    output wire                   volatileClearReq,
    input  wire                   volatileClearDone,
    output wire                   flashEraseReq,
    input  wire                   flashEraseDone,
    output wire                   protClearReq,
    input  wire                   protClearDone
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg  [`JTDA_PINS+3:0] syncA_q;
    reg  [`JTDA_PINS+3:0] syncB_q;
    reg        tckPrev_q;
    reg        extPrev_q;
    wire       tckS   = syncB_q[0];
    wire       tmsS   = syncB_q[1];
    wire       tdiS   = syncB_q[2];
    wire       extS   = syncB_q[3];
    wire       tckRise = tckS & ~tckPrev_q;
    wire       tckFall = ~tckS & tckPrev_q;
    wire       extRelease = extS & ~extPrev_q;

    // tck is sampled, never used as a clock; keep it well below clk / 4
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_q   <= {(`JTDA_PINS+4){1'b0}};
            syncB_q   <= {(`JTDA_PINS+4){1'b0}};
            tckPrev_q <= 1'b0;
            extPrev_q <= 1'b0;
        end else begin
            syncA_q   <= {padIn, extResetnPin, tdiPin, tmsPin, tckPin};
            syncB_q   <= syncA_q;
            tckPrev_q <= syncB_q[0];
            extPrev_q <= syncB_q[3];
        end
    end

    // ****************************************
    // pin enable and core hold at reset release
    // ****************************************
    reg armEnable_q;
    reg pinsEn_q;
    reg holdReq_q;
    reg relBit_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armEnable_q <= 1'b0;
            pinsEn_q    <= 1'b0;
            holdReq_q   <= 1'b0;
        end else if (!extS) begin
            armEnable_q <= 1'b0;
            pinsEn_q    <= 1'b0;
            holdReq_q   <= 1'b0;
        end else if (extRelease) begin
            armEnable_q <= ~tckS;
            holdReq_q   <= ~tckS;
        end else if (armEnable_q && tckFall) begin
            pinsEn_q    <= 1'b1;
        end
    end

    assign jtagEnabled = pinsEn_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            relBit_q       <= 1'b0;
            coreRestartReq <= 1'b0;
        end else begin
            coreRestartReq <= 1'b0;
            if (!extS || extRelease) begin
                relBit_q <= 1'b0;
            end else if (releaseCoreWr && !protectedState) begin
                relBit_q       <= releaseCoreVal;
                coreRestartReq <= relBit_q & ~releaseCoreVal;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coreHoldReset <= 1'b1;
        end else begin
            coreHoldReset <= ~extS | (holdReq_q & ~relBit_q);
        end
    end

    assign coreHoldStatus     = holdReq_q & ~relBit_q;
    assign busAccessEnable    = ~protectedState;
    assign pageBufWriteEnable = ~protectedState & ~coreHoldReset;

    // ****************************************
    // protected state and chip erase
    // ****************************************
    reg [2:0] erState_q;
    reg [2:0] erState_d;
    always @* begin
        erState_d = erState_q;
        case (erState_q)
            `JTDA_ER_IDLE:  if (eraseTriggerWr) erState_d = `JTDA_ER_VOL;
            `JTDA_ER_VOL:   if (volatileClearDone) erState_d = `JTDA_ER_FLASH;
            `JTDA_ER_FLASH: if (flashEraseDone) erState_d = `JTDA_ER_PROT;
            `JTDA_ER_PROT:  if (protClearDone) erState_d = `JTDA_ER_DONE;
            `JTDA_ER_DONE:  erState_d = `JTDA_ER_IDLE;
            default:        erState_d = `JTDA_ER_IDLE;
        endcase
    end

    // user page is untouched: flashEraseReq covers the main array only
    assign volatileClearReq = (erState_q == `JTDA_ER_VOL);
    assign flashEraseReq    = (erState_q == `JTDA_ER_FLASH);
    assign protClearReq     = (erState_q == `JTDA_ER_PROT);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erState_q     <= `JTDA_ER_IDLE;
            eraseComplete <= 1'b0;
        end else begin
            erState_q <= erState_d;
            if (erState_q == `JTDA_ER_DONE) begin
                eraseComplete <= 1'b1;
            end else if (erState_q == `JTDA_ER_IDLE && eraseTriggerWr) begin
                eraseComplete <= 1'b0;
            end
        end
    end

    // programming only shows after a reset release, hence the sample point
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            protectedState <= 1'b0;
        end else if (erState_q == `JTDA_ER_PROT && protClearDone) begin
            protectedState <= 1'b0;
        end else if (extRelease) begin
            protectedState <= protectProgrammed;
        end
    end

    // ****************************************
    // tap state machine
    // ****************************************
    reg [3:0] tap_q;
    reg [3:0] tap_d;
    wire      tapReset = ~pinsEn_q | ~extS;

    always @* begin
        tap_d = tap_q;
        case (tap_q)
            `JTDA_ST_RESET:   tap_d = tmsS ? `JTDA_ST_RESET : `JTDA_ST_IDLE;
            `JTDA_ST_IDLE:    tap_d = tmsS ? `JTDA_ST_SELDR : `JTDA_ST_IDLE;
            `JTDA_ST_SELDR:   tap_d = tmsS ? `JTDA_ST_SELIR : `JTDA_ST_CAPDR;
            `JTDA_ST_CAPDR:   tap_d = tmsS ? `JTDA_ST_EX1DR : `JTDA_ST_SHDR;
            `JTDA_ST_SHDR:    tap_d = tmsS ? `JTDA_ST_EX1DR : `JTDA_ST_SHDR;
            `JTDA_ST_EX1DR:   tap_d = tmsS ? `JTDA_ST_UPDDR : `JTDA_ST_PAUSEDR;
            `JTDA_ST_PAUSEDR: tap_d = tmsS ? `JTDA_ST_EX2DR : `JTDA_ST_PAUSEDR;
            `JTDA_ST_EX2DR:   tap_d = tmsS ? `JTDA_ST_UPDDR : `JTDA_ST_SHDR;
            `JTDA_ST_UPDDR:   tap_d = tmsS ? `JTDA_ST_SELDR : `JTDA_ST_IDLE;
            `JTDA_ST_SELIR:   tap_d = tmsS ? `JTDA_ST_RESET : `JTDA_ST_CAPIR;
            `JTDA_ST_CAPIR:   tap_d = tmsS ? `JTDA_ST_EX1IR : `JTDA_ST_SHIR;
            `JTDA_ST_SHIR:    tap_d = tmsS ? `JTDA_ST_EX1IR : `JTDA_ST_SHIR;
            `JTDA_ST_EX1IR:   tap_d = tmsS ? `JTDA_ST_UPDIR : `JTDA_ST_PAUSEIR;
            `JTDA_ST_PAUSEIR: tap_d = tmsS ? `JTDA_ST_EX2IR : `JTDA_ST_PAUSEIR;
            `JTDA_ST_EX2IR:   tap_d = tmsS ? `JTDA_ST_UPDIR : `JTDA_ST_SHIR;
            `JTDA_ST_UPDIR:   tap_d = tmsS ? `JTDA_ST_SELDR : `JTDA_ST_IDLE;
            default:          tap_d = `JTDA_ST_RESET;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tap_q <= `JTDA_ST_RESET;
        end else if (tapReset) begin
            tap_q <= `JTDA_ST_RESET;
        end else if (tckRise) begin
            tap_q <= tap_d;
        end
    end

    // ****************************************
    // instruction register
    // ****************************************
    reg [`JTDA_IR_W-1:0] irShift_q;
    reg [`JTDA_IR_W-1:0] ir_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irShift_q <= `JTDA_IR_CAPTURE;
            ir_q      <= `JTDA_INS_IDCODE;
        end else if (tapReset || (tckRise && tap_q == `JTDA_ST_RESET)) begin
            ir_q      <= `JTDA_INS_IDCODE;
        end else if (tckRise) begin
            case (tap_q)
                `JTDA_ST_CAPIR: irShift_q <= `JTDA_IR_CAPTURE;
                `JTDA_ST_SHIR:  irShift_q <= {tdiS, irShift_q[`JTDA_IR_W-1:1]};
                `JTDA_ST_UPDIR: ir_q      <= irShift_q;
                default:        ir_q      <= ir_q;
            endcase
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    function isBoundary;
        input [`JTDA_IR_W-1:0] ins;
        begin
            isBoundary = (ins == `JTDA_INS_EXTEST) || (ins == `JTDA_INS_SAMPLE);
        end
    endfunction

    reg                   bypass_q;
    reg [`JTDA_ID_W-1:0]  idShift_q;
    reg [`JTDA_BSR_W-1:0] bsrShift_q;
    reg [`JTDA_BSR_W-1:0] bsrUpd_q;
    wire [`JTDA_BSR_W-1:0] bsrCapture;

    // cell order per pin: input, output value, output enable
    genvar gi;
    generate
        for (gi = 0; gi < `JTDA_PINS; gi = gi + 1) begin : gCell
            assign bsrCapture[3*gi]   = syncB_q[4+gi];
            assign bsrCapture[3*gi+1] = coreOut[gi];
            assign bsrCapture[3*gi+2] = coreOe[gi];
        end
    endgenerate

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bypass_q   <= 1'b0;
            idShift_q  <= {`JTDA_ID_W{1'b0}};
            bsrShift_q <= {`JTDA_BSR_W{1'b0}};
            bsrUpd_q   <= {`JTDA_BSR_W{1'b0}};
        end else if (tckRise) begin
            case (tap_q)
                `JTDA_ST_CAPDR: begin
                    bypass_q  <= 1'b0;
                    idShift_q <= ID_CODE;
                    if (isBoundary(ir_q)) bsrShift_q <= bsrCapture;
                end
                `JTDA_ST_SHDR: begin
                    if (ir_q == `JTDA_INS_IDCODE) begin
                        idShift_q <= {tdiS, idShift_q[`JTDA_ID_W-1:1]};
                    end else if (isBoundary(ir_q)) begin
                        bsrShift_q <= {tdiS, bsrShift_q[`JTDA_BSR_W-1:1]};
                    end else begin
                        bypass_q <= tdiS;
                    end
                end
                `JTDA_ST_UPDDR: if (isBoundary(ir_q)) bsrUpd_q <= bsrShift_q;
                default:        bypass_q <= bypass_q;
            endcase
        end
    end

    // ****************************************
    // tdo, changed on tck falling edge
    // ****************************************
    reg tdoBit;

    always @* begin
        if (tap_q == `JTDA_ST_SHIR) begin
            tdoBit = irShift_q[0];
        end else if (ir_q == `JTDA_INS_IDCODE) begin
            tdoBit = idShift_q[0];
        end else if (isBoundary(ir_q)) begin
            tdoBit = bsrShift_q[0];
        end else begin
            tdoBit = bypass_q;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tapReset) begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdo   <= tdoBit;
            tdoOe <= (tap_q == `JTDA_ST_SHIR) || (tap_q == `JTDA_ST_SHDR);
        end
    end

    // ****************************************
    // pad multiplexer
    // ****************************************
    integer pi;

    // synced reset level only: pads float a few clocks after the pin drops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            padOut <= {`JTDA_PINS{1'b0}};
            padOe  <= {`JTDA_PINS{1'b0}};
        end else begin
            for (pi = 0; pi < `JTDA_PINS; pi = pi + 1) begin
                if (ir_q == `JTDA_INS_EXTEST && pinsEn_q) begin
                    padOut[pi] <= bsrUpd_q[3*pi+1];
                    padOe[pi]  <= bsrUpd_q[3*pi+2] & extS;
                end else begin
                    padOut[pi] <= coreOut[pi];
                    padOe[pi]  <= coreOe[pi] & extS;
                end
            end
        end
    end

endmodule // jtda_tap

// >>> jtda_consts.vh
`ifndef JTDA_CONSTS_VH
`define JTDA_CONSTS_VH

// ****************************************
// tap controller states
// ****************************************
`define JTDA_ST_RESET    4'hf
`define JTDA_ST_IDLE     4'hc
`define JTDA_ST_SELDR    4'h7
`define JTDA_ST_CAPDR    4'h6
`define JTDA_ST_SHDR     4'h2
`define JTDA_ST_EX1DR    4'h1
`define JTDA_ST_PAUSEDR  4'h3
`define JTDA_ST_EX2DR    4'h0
`define JTDA_ST_UPDDR    4'h5
`define JTDA_ST_SELIR    4'h4
`define JTDA_ST_CAPIR    4'he
`define JTDA_ST_SHIR     4'ha
`define JTDA_ST_EX1IR    4'h9
`define JTDA_ST_PAUSEIR  4'hb
`define JTDA_ST_EX2IR    4'h8
`define JTDA_ST_UPDIR    4'hd

// ****************************************
// instructions and widths
// ****************************************
`define JTDA_IR_W        4
`define JTDA_IR_CAPTURE  4'h1
`define JTDA_INS_EXTEST  4'h0
`define JTDA_INS_IDCODE  4'h1
`define JTDA_INS_SAMPLE  4'h2
`define JTDA_INS_BYPASS  4'hf
`define JTDA_ID_W        32
`define JTDA_IDCODE_DEF  32'h5a5a_a001
`define JTDA_PINS        8
`define JTDA_BSR_W       24

// ****************************************
// erase sequencer states
// ****************************************
`define JTDA_ER_IDLE     3'h0
`define JTDA_ER_VOL      3'h1
`define JTDA_ER_FLASH    3'h2
`define JTDA_ER_PROT     3'h3
`define JTDA_ER_DONE     3'h4

`endif

// >>> jtda_tap_sva.sv
`include "jtda_consts.vh"
// ****************************************
// port checker
// ****************************************
module jtda_tap_sva (
    // clock and reset
    input logic                  clk,
    input logic                  resetn,
    // pins
    input logic                  extResetnPin,
    input logic [`JTDA_PINS-1:0] padOe,
    input logic                  tdoOe,
    input logic                  jtagEnabled,
    // access port
    input logic                  releaseCoreWr,
    input logic                  releaseCoreVal,
    input logic                  eraseTriggerWr,
    input logic                  protectProgrammed,
    input logic                  coreHoldReset,
    input logic                  coreHoldStatus,
    input logic                  coreRestartReq,
    input logic                  busAccessEnable,
    input logic                  pageBufWriteEnable,
    input logic                  protectedState,
    input logic                  eraseComplete,
    // erase handshakes
    input logic                  volatileClearReq,
    input logic                  volatileClearDone,
    input logic                  flashEraseReq,
    input logic                  flashEraseDone,
    input logic                  protClearReq,
    input logic                  protClearDone
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire erIdle = !volatileClearReq && !flashEraseReq && !protClearReq;

    AST_PADS_FLOAT: assert property (!extResetnPin [*5] |-> padOe == '0)
        else $error("pads driven in external reset");
    AST_HOLD_IN_RESET: assert property (!extResetnPin [*5] |-> coreHoldReset)
        else $error("core not held in external reset");
    AST_RELEASE: assert property (releaseCoreWr && releaseCoreVal &&
        !protectedState && extResetnPin |=> !coreHoldStatus ##1 !coreHoldReset)
        else $error("release write did not free core");
    AST_PAGEBUF: assert property (pageBufWriteEnable |-> !coreHoldReset && !protectedState)
        else $error("page buffer open under hold or protection");
    AST_BUS_PROT: assert property (protectedState |-> !busAccessEnable)
        else $error("bus open while protected");
    AST_ER_START: assert property (eraseTriggerWr && erIdle && !$past(protClearReq)
        |=> volatileClearReq && !flashEraseReq)
        else $error("erase did not start with volatile clear");
    AST_ER_FLASH: assert property (volatileClearReq && volatileClearDone
        |=> flashEraseReq && !volatileClearReq)
        else $error("flash erase not next");
    AST_ER_PROT: assert property (flashEraseReq && flashEraseDone |=> protClearReq)
        else $error("protection clear not next");
    AST_ER_DONE: assert property (protClearReq && protClearDone
        |=> !protectedState ##[0:1] eraseComplete)
        else $error("erase completion flag late");
    AST_RESTART: assert property (coreRestartReq |=> !coreRestartReq && coreHoldReset)
        else $error("restart pulse too long or core free");
    AST_PINS_OFF: assert property (!jtagEnabled |-> !tdoOe)
        else $error("tdo driven with pins disabled");
    AST_PROT_LATCH: assert property ((protectProgrammed && !protectedState
        && extResetnPin) [*8] |=> !protectedState)
        else $error("protection applied without reset");

    COV_ERASE: cover property ($rose(eraseComplete));
    COV_RESTART: cover property (coreRestartReq);
    COV_PINS: cover property ($rose(jtagEnabled));
endmodule // jtda_tap_sva

bind jtda_tap jtda_tap_sva i_sva (.clk, .resetn, .extResetnPin, .padOe, .tdoOe, .jtagEnabled,
    .releaseCoreWr, .releaseCoreVal, .eraseTriggerWr, .protectProgrammed, .coreHoldReset,
    .coreHoldStatus, .coreRestartReq, .busAccessEnable, .pageBufWriteEnable, .protectedState,
    .eraseComplete, .volatileClearReq, .volatileClearDone, .flashEraseReq, .flashEraseDone,
    .protClearReq, .protClearDone);

// >>> jtda_dbg_model.sv
// ****************************************
// debugger model
// ****************************************
module jtda_dbg_model (
    // clock
    input  logic clk,
    // jtag pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rxData;
    logic        tdoBit;
    event        scanEv;

    // tck low from time zero: release then arms core hold
    initial begin
        {tck, tms, tdi} = 3'b010;
        rxData = '0;
    end
    // half period of 24 ns, tck stands still between frames
    task automatic half();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic tick(input logic m, input logic d);
        tck = 1'b0;
        tms = m;
        tdi = d;
        half();
        tck = 1'b1;
        tdoBit = tdo;
        half();
    endtask
    // tdi is junk outside shift states
    task automatic navs(input logic [3:0] p, input int n);
        for (int i = 0; i < n; i++) tick(p[i], ~tdi);
    endtask
    // rising tck then fall enables pins; ends high so a later release keeps them off
    task automatic go_reset();
        tck = 1'b1;
        half();
        navs(4'b1111, 4);
        navs(4'b0001, 2);
    endtask
    task automatic scan_ir(input logic [3:0] ins, input logic toIdle, output logic [3:0] cap);
        navs(4'b0011, 4);
        for (int i = 0; i < 4; i++) begin
            tick(i == 3, ins[i]);
            cap[i] = tdoBit;
        end
        navs(toIdle ? 4'b0001 : 4'b0110, toIdle ? 2 : 3);
    endtask
    task automatic scan_dr(input int n, input logic [31:0] din);
        rxData = '0;
        navs(4'b0001, 3);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            rxData[i] = tdoBit;
        end
        navs(4'b0001, 2);
        -> scanEv;
    endtask
endmodule // jtda_dbg_model

// >>> tb.sv
`include "jtda_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [31:0] TbId = 32'h3c96_a5e1;  // arbitrary identification value
    logic                  clk, resetn, tckPin, tmsPin, tdiPin, tdo, tdoOe, extResetnPin;
    logic [`JTDA_PINS-1:0] padIn, padOut, padOe, coreOut, coreOe, expOut, expOe;
    logic                  releaseCoreWr, releaseCoreVal, eraseTriggerWr, protectProgrammed;
    logic                  coreHoldReset, coreHoldStatus, coreRestartReq, busAccessEnable;
    logic                  pageBufWriteEnable, protectedState, eraseComplete, jtagEnabled;
    logic                  volatileClearReq, flashEraseReq, protClearReq;
    logic [2:0]            dones;
    logic [3:0]            cap;
    logic [31:0]           seed = 32'h46f4, d, expQ[$], mskQ[$];
    int                    num_errors = 0, n_checks = 0, t, pulses;
    wire  [2:0]            reqs = {protClearReq, flashEraseReq, volatileClearReq};

    jtda_tap #(.ID_CODE(TbId)) i_dut (
        .clk, .resetn, .tckPin, .tmsPin, .tdiPin, .tdo, .tdoOe, .extResetnPin, .padIn,
        .padOut, .padOe, .coreOut, .coreOe, .releaseCoreWr, .releaseCoreVal, .eraseTriggerWr,
        .protectProgrammed, .coreHoldReset, .coreHoldStatus, .coreRestartReq,
        .busAccessEnable, .pageBufWriteEnable, .protectedState, .eraseComplete, .jtagEnabled,
        .volatileClearReq, .volatileClearDone(dones[0]), .flashEraseReq,
        .flashEraseDone(dones[1]), .protClearReq, .protClearDone(dones[2]));
    jtda_dbg_model i_dbg (.clk, .tck(tckPin), .tms(tmsPin), .tdi(tdiPin),
        .tdo(tdoOe ? tdo : ~tdo));

    // ****************************************
    // helpers
    // ****************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] in_cells(input logic [7:0] p);
        in_cells = '0;
        for (int i = 0; i < 8; i++) in_cells[3*i] = p[i];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic err(input string msg);
        $display("ERROR %0t: %s", $time, msg);
        num_errors++;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) err(msg);
    endtask
    task automatic note(input logic [31:0] ex, input logic [31:0] msk);
        expQ.push_back(ex);
        mskQ.push_back(msk);
    endtask
    task automatic release_wr(input logic v);
        releaseCoreVal = v;
        releaseCoreWr = 1'b1;
        cyc(1);
        releaseCoreWr = 1'b0;
    endtask
    task automatic extest_check();
        for (int i = 0; i < 8; i++) {expOut[i], expOe[i]} = {d[3*i+1], d[3*i+2]};
        chk({padOut, padOe}, {expOut, expOe}, "boundary latches not on pads");
    endtask
    task automatic erase_run();
        eraseTriggerWr = 1'b1;
        cyc(1);
        eraseTriggerWr = 1'b0;
        for (int k = 0; k < 3; k++) begin
            for (t = 0; t < 40 && reqs !== 3'b001 << k; t++) cyc(1);
            chk(reqs, 3'b001 << k, "erase phase order");
            if (k == 0) chk(eraseComplete, 1'b0, "flag not cleared");
            eraseTriggerWr = (k == 1);  // refused while busy
            cyc(1 + rnd() % 6);
            eraseTriggerWr = 1'b0;
            dones = 3'b001 << k;
            cyc(1);
            dones = 3'b000;
        end
        for (t = 0; t < 40 && eraseComplete !== 1'b1; t++) cyc(1);
        cyc(3);
        chk({eraseComplete, protectedState, reqs}, 5'b10000, "erase end");
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, scan monitor
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        cyc(20000);
        err("timeout");
        print_verdict();
    end
    initial forever begin
        logic [31:0] ex, mk;
        @(i_dbg.scanEv);
        ex = expQ.pop_front();
        mk = mskQ.pop_front();
        n_checks++;
        if ((i_dbg.rxData & mk) !== (ex & mk)) err("scan data mismatch");
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn, extResetnPin, releaseCoreWr, releaseCoreVal, eraseTriggerWr} = '0;
        {protectProgrammed, dones} = '0;
        d = rnd();
        {padIn, coreOut, coreOe} = d[23:0];
        cyc(16);
        resetn = 1'b1;
        cyc(2);
        chk({coreHoldReset, jtagEnabled, padOe}, 10'h200, "reset state");
        extResetnPin = 1'b1;
        cyc(8);
        chk({coreHoldReset, coreHoldStatus, pageBufWriteEnable}, 3'b110, "hold");
        i_dbg.go_reset();
        chk(jtagEnabled, 1'b1, "pins not enabled");
        note(TbId, '1);
        i_dbg.scan_dr(32, rnd());
        i_dbg.scan_ir(`JTDA_INS_BYPASS, 1'b0, cap);
        chk(cap, `JTDA_IR_CAPTURE, "ir capture");
        d = rnd();
        note({d[6:0], 1'b0}, 32'hff);
        i_dbg.scan_dr(8, d);
        d = rnd();
        i_dbg.scan_ir(`JTDA_INS_SAMPLE, 1'b1, cap);
        note(in_cells(padIn), 32'h249249);
        i_dbg.scan_dr(24, d);
        chk({padOut, padOe}, {coreOut, coreOe}, "sample disturbed pads");
        i_dbg.scan_ir(`JTDA_INS_EXTEST, 1'b1, cap);
        extest_check();
        d = rnd() | 32'h924924;
        padIn = ~padIn;
        note(in_cells(padIn), 32'h249249);
        i_dbg.scan_dr(24, d);
        extest_check();
        protectProgrammed = 1'b1;
        release_wr(1'b1);
        cyc(1);
        chk({coreHoldReset, coreHoldStatus, pageBufWriteEnable, busAccessEnable, protectedState},
            5'b00110, "release");
        release_wr(1'b0);
        pulses = 0;
        repeat (4) begin
            pulses += (coreRestartReq === 1'b1);
            cyc(1);
        end
        chk(pulses, 1, "restart pulse");
        chk(coreHoldReset, 1'b1, "hold not back");
        extResetnPin = 1'b0;
        cyc(4);
        chk(padOe, '0, "pads not floating");
        extResetnPin = 1'b1;
        cyc(8);
        chk({jtagEnabled, protectedState, busAccessEnable, pageBufWriteEnable, coreHoldReset},
            5'b01000, "release with tck high");
        repeat (2) erase_run();
        print_verdict();
    end
endmodule // tb
